// ===== stio_edge_det.sv
`timescale 1ns/1ps
`default_nettype none
module stio_edge_det (
  input  wire logic   pclk,
  input  wire logic   presetn,
  stio_trig_if.det    trig
);
  logic prev;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev <= 1'b0;
    end else begin
      prev <= trig.pin_sync;
    end
  end

  // Polarity 0 takes rising edges, 1 takes falling edges.
  assign trig.start_req = trig.edge_pol ? (prev & ~trig.pin_sync)
                                        : (~prev & trig.pin_sync);
endmodule
`default_nettype wire

// ===== stio_instr.sv
`timescale 1ns/1ps
`default_nettype none
// Drives the trigger pin like bench equipment; the level holds for many cycles,
// so the two-flop synchroniser always sees it.
module stio_instr (
  input  wire logic pclk,
  input  wire logic trig_out,
  output var logic  trig_in
);
  int unsigned marks = 0;
  logic        last  = 1'b0;
  initial trig_in = 1'b0;
  always @(posedge pclk) begin
    if (trig_out && !last) marks++;
    last <= trig_out;
  end
  task automatic level(input logic v);
    @(posedge pclk);
    trig_in <= v;
    repeat (4) @(posedge pclk);
  endtask
endmodule
`default_nettype wire

// ===== stio_pkg.sv
package stio_pkg;

  // ------------------------------------------------------------------
  // Clock and timing
  // ------------------------------------------------------------------
  localparam int unsigned CLK_HZ         = 250_000_000;
  localparam int unsigned TICK_NS        = 1000;
  localparam int unsigned CLK_PERIOD_NS  = 4;
  localparam int unsigned TICK_CYCLES    = TICK_NS / CLK_PERIOD_NS;
  localparam int unsigned SWEEP_MIN_MS   = 1;
  localparam int unsigned SWEEP_MAX_S    = 500;
  localparam logic [31:0] SWEEP_MIN_US   = 32'h0000_03E8;
  localparam logic [31:0] SWEEP_MAX_US   = 32'h1DCD_6500;
  localparam logic [31:0] SWEEP_RST_US   = 32'h000F_4240;
  localparam int unsigned PULSE_US       = 1;

  // ------------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------------
  localparam logic [11:0] CTRL_OFS       = 12'h000;
  localparam logic [11:0] TIME_OFS       = 12'h004;
  localparam logic [11:0] CMD_OFS        = 12'h008;
  localparam logic [11:0] STAT_OFS       = 12'h00C;
  localparam logic [11:0] CNT_OFS        = 12'h010;

  localparam int unsigned CTRL_SRC_LSB   = 0;
  localparam int unsigned CTRL_IN_POL    = 2;
  localparam int unsigned CTRL_OUT_POL   = 3;
  localparam int unsigned CTRL_OUT_EN    = 4;
  localparam int unsigned CTRL_SWEEP_ON  = 5;
  localparam int unsigned CMD_SW_TRIG    = 0;
  localparam int unsigned CMD_IF_RESET   = 1;
  localparam logic [31:0] CTRL_RST       = 32'h0000_0000;

  typedef enum logic [1:0] {
    STIO_SRC_INT = 2'd0,
    STIO_SRC_EXT = 2'd1,
    STIO_SRC_MAN = 2'd2
  } stio_src_e;

endpackage

// ===== stio_properties.sv
`timescale 1ns/1ps
`default_nettype none
module stio_properties (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [11:0] paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        sweep_active,
  input wire logic        sweep_start
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence access_s;
    psel && penable;
  endsequence
  sequence begin_s;
    $rose(sweep_active);
  endsequence
  apb_answer_a: assert property (access_s |-> pready)
    else $error("access cycle without pready");
  ready_only_a: assert property (pready |-> psel && penable)
    else $error("pready outside access");
  err_qualified_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  unmapped_err_a: assert property (access_s and (paddr > 12'h010) |-> pslverr)
    else $error("unmapped access not refused");
  start_single_a: assert property (sweep_start |=> !sweep_start)
    else $error("start pulse longer than one cycle");
  start_in_sweep_a: assert property (sweep_start |-> sweep_active)
    else $error("start pulse outside sweep");
  start_follows_a: assert property (begin_s |-> ##[0:2] sweep_start)
    else $error("sweep began without start pulse");
  sweep_hold_a: assert property (begin_s |=> sweep_active [*8])
    else $error("sweep shorter than minimum");
endmodule
bind stio_top stio_properties u_props (.pclk, .presetn, .psel, .penable, .paddr,
  .pready, .pslverr, .sweep_active, .sweep_start);
`default_nettype wire

// ===== stio_top.sv
// Our own choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - one sweep per selected external edge (the code ignores edges that arrive while a sweep is running)
// - trigger out driven only when sweep and enabled
// - active edge at sweep start, rising default
// - internal source: 50% square, edge at start
// - internal square period equals sweep time
// - manual source: one pulse per software sweep
// - source internal/external/manual, internal after reset
// - input polarity picks rising or falling edge
// - hold start frequency until next trigger
// - sweep time spans 1 ms to 500 s
module stio_top
  import stio_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        trig_in,
  output logic             trig_out,
  output logic             sweep_active,
  output logic             sweep_start
);

  // ------------------------------------------------------------------
  // Configuration registers
  // ------------------------------------------------------------------
  stio_src_e   src;
  logic        in_pol;
  logic        out_pol;
  logic        out_en;
  logic        sweep_on;
  logic [31:0] sweep_us;
  logic [31:0] sweep_cnt;
  logic        sw_trig;
  logic        wr_acc;
  logic        rd_acc;
  logic        addr_ok;
  logic        if_reset;
  logic        wr_ctrl;
  logic        wr_time;
  logic        wr_cmd;
  stio_src_e   next_src;
  logic [31:0] next_prdata;

  // ------------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------------
  // Only the five offsets 0x000 to 0x010 are mapped; anything else answers with an error.
  always_comb begin
    case (paddr)
      CTRL_OFS: addr_ok = 1'b1;
      TIME_OFS: addr_ok = 1'b1;
      CMD_OFS:  addr_ok = 1'b1;
      STAT_OFS: addr_ok = 1'b1;
      CNT_OFS:  addr_ok = 1'b1;
      default:  addr_ok = 1'b0;
    endcase
  end

  // Writes land on the access edge; reads are latched on the setup edge.
  assign wr_acc   = psel && penable && pwrite;
  assign rd_acc   = psel && !penable && !pwrite;
  assign wr_ctrl  = wr_acc && (paddr == CTRL_OFS);
  assign wr_time  = wr_acc && (paddr == TIME_OFS);
  assign wr_cmd   = wr_acc && (paddr == CMD_OFS);
  assign if_reset = wr_cmd && pwdata[CMD_IF_RESET];

  // Code 3 is unused and falls back to the internal source.
  always_comb begin
    case (pwdata[CTRL_SRC_LSB +: 2])
      2'h1:    next_src = STIO_SRC_EXT;
      2'h2:    next_src = STIO_SRC_MAN;
      default: next_src = STIO_SRC_INT;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src      <= STIO_SRC_INT;
      in_pol   <= CTRL_RST[CTRL_IN_POL];
      out_pol  <= CTRL_RST[CTRL_OUT_POL];
      out_en   <= CTRL_RST[CTRL_OUT_EN];
      sweep_on <= CTRL_RST[CTRL_SWEEP_ON];
    end else if (if_reset) begin
      src <= STIO_SRC_INT;
    end else if (wr_ctrl) begin
      src      <= next_src;
      in_pol   <= pwdata[CTRL_IN_POL];
      out_pol  <= pwdata[CTRL_OUT_POL];
      out_en   <= pwdata[CTRL_OUT_EN];
      sweep_on <= pwdata[CTRL_SWEEP_ON];
    end
  end

  // Out-of-range sweep times are clamped so the period stays in range.
  // Software can read the clamped value back to see what is in force.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sweep_us <= SWEEP_RST_US;
    end else if (wr_time) begin
      if (pwdata < SWEEP_MIN_US) begin
        sweep_us <= SWEEP_MIN_US;
      end else if (pwdata > SWEEP_MAX_US) begin
        sweep_us <= SWEEP_MAX_US;
      end else begin
        sweep_us <= pwdata;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_trig <= 1'b0;
    end else begin
      // A one-cycle strobe: nothing has to be cleared before the next one.
      sw_trig <= wr_cmd && pwdata[CMD_SW_TRIG];
    end
  end

  // ------------------------------------------------------------------
  // Read-back mux
  // ------------------------------------------------------------------
  // Status is captured on the setup edge, one cycle before the access edge.
  always_comb begin
    case (paddr)
      CTRL_OFS: next_prdata = {26'h0, sweep_on, out_en, out_pol, in_pol, src};
      TIME_OFS: next_prdata = sweep_us;
      STAT_OFS: next_prdata = {30'h0, trig_out, sweep_active};
      CNT_OFS:  next_prdata = sweep_cnt;
      default:  next_prdata = 32'h0000_0000;
    endcase
  end

  // ------------------------------------------------------------------
  // APB answer: zero wait states, error on unmapped offsets
  // ------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      // The answer is raised on the setup edge so that it stands through the
      // whole access cycle; a refused access leaves every register untouched.
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
      if (rd_acc) begin
        prdata <= next_prdata;
      end
    end
  end

  // ------------------------------------------------------------------
  // Input synchroniser and edge detection
  // ------------------------------------------------------------------
  logic        sync1;
  logic        sync2;
  stio_trig_if trig ();

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
    end else begin
      sync1 <= trig_in;
      sync2 <= sync1;
    end
  end

  // Only the second stage feeds logic; the first may still be settling
  // after a pin edge that fell close to the clock.
  assign trig.pin_sync = sync2;
  assign trig.edge_pol = in_pol;

  // Edges are judged on the synchronised level, which adds two cycles of latency.
  stio_edge_det u_edge (
    .pclk    (pclk),
    .presetn (presetn),
    .trig    (trig)
  );

  // ------------------------------------------------------------------
  // Microsecond tick and sweep timer
  // ------------------------------------------------------------------
  logic [7:0]  tick_div;
  logic        tick;
  logic [31:0] elapsed;
  logic        start_now;
  logic        sweep_done;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_div <= 8'h00;
      tick     <= 1'b0;
    end else if (start_now) begin
      // Restart one count in, so the first tick comes exactly one microsecond
      // after the start and the sweep period is not stretched by a cycle.
      tick_div <= 8'h01;
      tick     <= 1'b0;
    end else begin
      tick     <= (tick_div == 8'(TICK_CYCLES - 1));
      tick_div <= (tick_div == 8'(TICK_CYCLES - 1)) ? 8'h00 : tick_div + 8'h01;
    end
  end

  // ------------------------------------------------------------------
  // Sweep sequencing
  // ------------------------------------------------------------------
  // The last tick of the last microsecond ends the sweep, and the internal
  // source restarts in that same cycle so consecutive periods leave no gap.
  assign sweep_done = sweep_active && tick && (elapsed == sweep_us - 32'h0000_0001);

  // A new trigger during a running sweep is ignored; internal restarts back to back.
  always_comb begin
    start_now = 1'b0;
    if (sweep_on) begin
      case (src)
        STIO_SRC_INT: start_now = !sweep_active || sweep_done;
        STIO_SRC_EXT: start_now = !sweep_active && trig.start_req;
        STIO_SRC_MAN: start_now = !sweep_active && sw_trig;
        default:      start_now = 1'b0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sweep_active <= 1'b0;
      elapsed      <= 32'h0000_0000;
    end else if (!sweep_on) begin
      // Turning sweeping off abandons a sweep in progress at once and leaves
      // the timer cleared for the next start.
      sweep_active <= 1'b0;
      elapsed      <= 32'h0000_0000;
    end else if (start_now) begin
      sweep_active <= 1'b1;
      elapsed      <= 32'h0000_0000;
    end else if (sweep_done) begin
      sweep_active <= 1'b0;
      elapsed      <= 32'h0000_0000;
    end else if (sweep_active && tick) begin
      elapsed <= elapsed + 32'h0000_0001;
    end
  end

  // ------------------------------------------------------------------
  // Start marker and sweep counter
  // ------------------------------------------------------------------
  // The counter wraps after 2**32 sweeps; software reads it as a running tally.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sweep_start <= 1'b0;
      sweep_cnt   <= 32'h0000_0000;
    end else begin
      sweep_start <= start_now;
      if (start_now) begin
        sweep_cnt <= sweep_cnt + 32'h0000_0001;
      end
    end
  end

  // ------------------------------------------------------------------
  // Trigger output shaping
  // ------------------------------------------------------------------
  logic phase_high;

  // Active phase lasts the first half of the sweep, or one tick for a pulse.
  // An odd sweep time leaves the inactive half one microsecond longer.
  always_comb begin
    phase_high = 1'b0;
    if (start_now) begin
      phase_high = 1'b1;
    end else if (sweep_active) begin
      if (src == STIO_SRC_INT) begin
        phase_high = elapsed < (sweep_us >> 1);
      end else begin
        phase_high = elapsed < 32'(PULSE_US);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_out <= 1'b0;
    end else if (!(out_en && sweep_on)) begin
      // Forcing the pin low (the idle level only when out_pol is 0) keeps stray edges off the pin while the output
      // or sweeping is off.
      trig_out <= 1'b0;
    end else begin
      trig_out <= phase_high ^ out_pol;
    end
  end

endmodule
`default_nettype wire

// ===== stio_trig_if.sv
`timescale 1ns/1ps
`default_nettype none
interface stio_trig_if;
  logic pin_sync;
  logic edge_pol;
  logic start_req;
  modport det (input pin_sync, input edge_pol, output start_req);
  modport top (output pin_sync, output edge_pol, input start_req);
endinterface
`default_nettype wire

// ===== test_sweep_trigger_io.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin num_errors++; \
  $display("mismatch %0t got %h exp %h", $time, a, b); end end
module test_sweep_trigger_io;
  import stio_pkg::*;
  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        trig_in;
  logic        trig_out;
  logic        sweep_active;
  logic        sweep_start;
  logic [33:0] exp_q[$];
  logic [33:0] e;
  logic [31:0] lfsr = 32'hcd4c_4a58;
  int          num_errors = 0;
  int          n_checks = 0;
  int          starts = 0;
  always #2 pclk = ~pclk;
  stio_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .trig_in, .trig_out, .sweep_active, .sweep_start);
  stio_instr PEER (.pclk, .trig_out, .trig_in);
  // Each note is {is_read, expected error, expected data}.
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      e = exp_q.pop_front();
      `CHK(pslverr, e[32])
      if (e[33]) `CHK(prdata, e[31:0])
    end
  end
  // Counts start markers since the last reset.
  always @(posedge pclk) begin
    if (!presetn) starts = 0;
    else if (sweep_start === 1'b1) starts++;
  end
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [33:0] x);
    int n;
    n = 0;
    exp_q.push_back(x);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && ++n < 50);
    if (pready !== 1'b1) num_errors++;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 34'h0);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] d);
    apb(1'b0, a, 32'h0, {2'b10, d});
  endtask
  task automatic do_reset();
    presetn <= 1'b0;
    pwrite  <= 1'b0;
    paddr   <= lfsr[11:0];
    pwdata  <= lfsr;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
  endtask
  // Bounded so a dead trigger path shows up as a failed read, not a hang.
  task automatic settle();
    int n;
    n = 0;
    while (sweep_active !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
  endtask
  task automatic final_report();
    if (num_errors == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    logic [31:0] v;
    do_reset();
    rd(CTRL_OFS, CTRL_RST);
    rd(TIME_OFS, SWEEP_RST_US);
    rd(STAT_OFS, 32'h0000_0000);
    apb(1'b0, 12'h020, 32'h0, {2'b11, 32'h0});
    wr(TIME_OFS, 32'h0000_0005);
    rd(TIME_OFS, SWEEP_MIN_US);
    repeat (4) begin
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      v = lfsr >> lfsr[4:0];
      wr(TIME_OFS, v);
      rd(TIME_OFS, v < SWEEP_MIN_US ? SWEEP_MIN_US : v > SWEEP_MAX_US ? SWEEP_MAX_US : v);
    end
    wr(TIME_OFS, SWEEP_MIN_US);
    wr(CTRL_OFS, 32'h0000_0031);
    rd(STAT_OFS, 32'h0000_0000);
    PEER.level(1'b1);
    settle();
    rd(STAT_OFS, 32'h0000_0003);
    PEER.level(1'b0);
    PEER.level(1'b1);
    repeat (300) @(posedge pclk);
    rd(STAT_OFS, 32'h0000_0001);
    rd(CNT_OFS, 32'h0000_0001);
    `CHK(PEER.marks, 1)
    `CHK(starts, 1)
    do_reset();
    wr(CTRL_OFS, 32'h0000_003D);
    PEER.level(1'b0);
    PEER.level(1'b1);
    rd(CNT_OFS, 32'h0000_0001);
    `CHK(starts, 1)
    do_reset();
    PEER.level(1'b0);
    do_reset();
    wr(CTRL_OFS, 32'h0000_003D);
    PEER.level(1'b1);
    rd(CNT_OFS, 32'h0000_0000);
    `CHK(starts, 0)
    PEER.level(1'b0);
    settle();
    rd(STAT_OFS, 32'h0000_0001);
    do_reset();
    wr(CTRL_OFS, 32'h0000_0030);
    settle();
    rd(STAT_OFS, 32'h0000_0003);
    `CHK(starts, 1)
    repeat (300) @(posedge pclk);
    rd(STAT_OFS, 32'h0000_0003);
    wr(CTRL_OFS, 32'h0000_0020);
    rd(STAT_OFS, 32'h0000_0001);
    do_reset();
    wr(CTRL_OFS, 32'h0000_0032);
    rd(CNT_OFS, 32'h0000_0000);
    wr(CMD_OFS, 32'h0000_0001);
    settle();
    rd(STAT_OFS, 32'h0000_0003);
    `CHK(starts, 1)
    repeat (300) @(posedge pclk);
    rd(STAT_OFS, 32'h0000_0001);
    wr(CMD_OFS, 32'h0000_0002);
    rd(CTRL_OFS, 32'h0000_0030);
    final_report();
  end
  initial begin
    #80000;
    num_errors++;
    final_report();
  end
endmodule
`default_nettype wire
